// >>> bmrp_consts.vh
`ifndef BMRP_CONSTS_VH
`define BMRP_CONSTS_VH

`define BMRP_PAGE_CFG 2'h0
`define BMRP_PAGE_STAT 2'h1
`define BMRP_PAGE_MEAS 2'h2
`define BMRP_PAGE_USER 2'h3

`define BMRP_OFS_PACK_CONTROL 5'h00
`define BMRP_OFS_DELAY_SELECT 5'h01
`define BMRP_OFS_LOW_CAP_THRESH 5'h02
`define BMRP_OFS_MAKER_ID_LO 5'h03
`define BMRP_OFS_MAKER_ID_HI 5'h04
`define BMRP_OFS_PAGE0_LAST 5'h04

`define BMRP_OFS_PACK_STATUS 5'h00
`define BMRP_OFS_TEMPERATURE 5'h01
`define BMRP_OFS_UNUSED_A 5'h02
`define BMRP_OFS_UNUSED_B 5'h03
`define BMRP_OFS_VOLTAGE_LO 5'h04
`define BMRP_OFS_VOLTAGE_HI 5'h05

`define BMRP_OFS_NET_CHARGE 5'h00
`define BMRP_OFS_PACK_CONFIG 5'h01
`define BMRP_OFS_CHARGE_IN_LO 5'h02
`define BMRP_OFS_CHARGE_IN_HI 5'h03
`define BMRP_OFS_CHARGE_OUT_LO 5'h04
`define BMRP_OFS_CHARGE_OUT_HI 5'h05
`define BMRP_OFS_CURRENT_LO 5'h06
`define BMRP_OFS_CURRENT_HI 5'h07

`define BMRP_RD_RESERVED 8'hFF
`define BMRP_RD_UNUSED 8'h00

`define BMRP_CTL_LOW_POWER 7
`define BMRP_CTL_REFRESH 6
`define BMRP_CTL_CHARGE_PIN 3
`define BMRP_CTL_DISCHARGE_PIN 2
`define BMRP_CTL_CHARGE_ALLOW 1
`define BMRP_CTL_DISCHARGE_ALLOW 0

`define BMRP_CFG_POR_FLAG 4
`define BMRP_CFG_FIXED_ONES 8'h0C
`define BMRP_CFG_WR_MASK 8'hF3

`define BMRP_RST_PACK_CONTROL 8'h03
`define BMRP_RST_DELAY_SELECT 8'h00
`define BMRP_RST_LOW_CAP_THRESH 8'h00
`define BMRP_RST_PACK_CONFIG 8'h83
`define BMRP_MAKER_ID_DEFAULT 16'h5A3C

`define BMRP_DLY_RELEASE_HI 7
`define BMRP_DLY_RELEASE_LO 6
`define BMRP_DLY_OVERVOLT_HI 5
`define BMRP_DLY_OVERVOLT_LO 4
`define BMRP_DLY_UNDERVOLT_HI 3
`define BMRP_DLY_UNDERVOLT_LO 2
`define BMRP_DLY_OVERCUR_HI 1
`define BMRP_DLY_OVERCUR_LO 0

`define BMRP_RELEASE_BASE_MS 512
`define BMRP_OVERVOLT_BASE_MS 512

`endif

// >>> bmrp_user_mem.v
`timescale 1ns/1ps
module bmrp_user_mem (
	input wire i_core_clk,
	input wire i_wr_en,
	input wire [4:0] i_addr,
	input wire [7:0] i_wdata,
	output wire [7:0] o_rdata
);
	// No reset: contents are undefined after power-on by design
	reg [7:0] mem_reg [0:31];

	always @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem_reg[i_addr] <= i_wdata;
		end
	end

	assign o_rdata = mem_reg[i_addr];
endmodule // bmrp_user_mem

// >>> bmrp_path_ctrl.v
`timescale 1ns/1ps
module bmrp_path_ctrl (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire [1:0] i_allow,
	input wire [1:0] i_block,
	output wire [1:0] o_drive_b
);
	genvar g;

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_path
			reg on_reg;

			always @(posedge i_core_clk) begin
				if (!i_rst_b) begin
					on_reg <= 1'b0;
				end else begin
					on_reg <= i_allow[g] & ~i_block[g];
				end
			end

			// Pins are active low: FET on when driven low
			assign o_drive_b[g] = ~on_reg;
		end
	endgenerate
endmodule // bmrp_path_ctrl

// >>> bmrp_regs.v
`timescale 1ns/1ps
`include "bmrp_consts.vh"
module bmrp_regs #(
	parameter [15:0] MAKER_ID = `BMRP_MAKER_ID_DEFAULT
) (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire [1:0] i_page,
	input wire [4:0] i_offset,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	output reg [7:0] o_rdata,
	output reg o_rd_valid,
	input wire i_lock_cmd,
	input wire i_unlock_cmd,
	input wire i_dq,
	input wire i_pio_pin,
	input wire i_over_temp,
	input wire i_over_volt,
	input wire i_under_volt,
	input wire i_over_current,
	input wire i_low_cap_warn,
	input wire i_charge_block,
	input wire i_discharge_block,
	input wire [7:0] i_temperature,
	input wire [9:0] i_voltage,
	input wire [15:0] i_current,
	output wire o_charge_pin_b,
	output wire o_discharge_pin_b,
	output wire o_low_power_request,
	output wire o_refresh_mode_request,
	output wire [1:0] o_overcurrent_release_time,
	output wire [1:0] o_overvoltage_delay,
	output wire [1:0] o_undervoltage_delay,
	output wire [1:0] o_overcurrent_delay,
	output wire [7:0] o_low_capacity_threshold,
	output wire [7:0] o_pack_configuration,
	output wire [7:0] o_net_charge_accumulator,
	output wire [15:0] o_charge_in_accumulator,
	output wire [15:0] o_charge_out_accumulator
);
	reg low_power_reg;
	reg refresh_reg;
	reg charge_allow_reg;
	reg discharge_allow_reg;
	reg [7:0] delay_select_reg;
	reg [7:0] low_cap_thresh_reg;
	reg [7:0] config_reg;
	reg write_guard_reg;
	reg pio_seen_reg;
	reg dq_prev_reg;
	reg [7:0] net_charge_reg;
	reg [15:0] charge_in_reg;
	reg [15:0] charge_out_reg;
	reg [7:0] rdata_next;
	wire [1:0] drive_b;
	wire [7:0] user_rdata;
	wire [7:0] control_rd;
	wire [7:0] status_rd;
	wire pg0_wr;
	wire pg2_wr;
	wire user_wr;
	wire dq_fall;
	wire ctl_wr;
	wire cfg_wr;
	wire pg1_access;
	wire [7:0] ctl_rst;

	assign ctl_rst = `BMRP_RST_PACK_CONTROL;
	// page and offset pick one byte
	// lock blocks page 0 writes only
	// A write beside unlock is refused: writes see the old guard
	assign pg0_wr = i_wr & (i_page == `BMRP_PAGE_CFG) & ~write_guard_reg;
	assign pg2_wr = i_wr & (i_page == `BMRP_PAGE_MEAS);
	assign user_wr = i_wr & (i_page == `BMRP_PAGE_USER);
	assign ctl_wr = pg0_wr & (i_offset == `BMRP_OFS_PACK_CONTROL);
	assign cfg_wr = pg2_wr & (i_offset == `BMRP_OFS_PACK_CONFIG);
	assign pg1_access = (i_rd | i_wr) & (i_page == `BMRP_PAGE_STAT);
	assign dq_fall = dq_prev_reg & ~i_dq;

	// lock and unlock
	// Lock wins a same-cycle clash so page 0 stays protected
	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			write_guard_reg <= 1'b1;
		end else if (i_lock_cmd) begin
			write_guard_reg <= 1'b1;
		end else if (i_unlock_cmd) begin
			write_guard_reg <= 1'b0;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			dq_prev_reg <= 1'b1;
		end else begin
			dq_prev_reg <= i_dq;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			low_power_reg <= ctl_rst[`BMRP_CTL_LOW_POWER];
			charge_allow_reg <= ctl_rst[`BMRP_CTL_CHARGE_ALLOW];
			discharge_allow_reg <= ctl_rst[`BMRP_CTL_DISCHARGE_ALLOW];
			low_cap_thresh_reg <= `BMRP_RST_LOW_CAP_THRESH;
		end else if (pg0_wr) begin
			case (i_offset)
				`BMRP_OFS_PACK_CONTROL: begin
					low_power_reg <= i_wdata[`BMRP_CTL_LOW_POWER];
					charge_allow_reg <= i_wdata[`BMRP_CTL_CHARGE_ALLOW];
					discharge_allow_reg <= i_wdata[`BMRP_CTL_DISCHARGE_ALLOW];
				end
				`BMRP_OFS_LOW_CAP_THRESH: begin
					low_cap_thresh_reg <= i_wdata;
				end
				default: begin
					low_cap_thresh_reg <= low_cap_thresh_reg;
				end
			endcase
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			delay_select_reg <= `BMRP_RST_DELAY_SELECT;
		end else if (pg0_wr && i_offset == `BMRP_OFS_DELAY_SELECT) begin
			delay_select_reg <= i_wdata;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			refresh_reg <= ctl_rst[`BMRP_CTL_REFRESH];
		end else if (dq_fall) begin
			// A fall beats a same-cycle write so refresh never sticks
			refresh_reg <= 1'b0;
		end else if (ctl_wr) begin
			refresh_reg <= i_wdata[`BMRP_CTL_REFRESH];
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			// Bits 3,2 are stored as ones so the port and reads agree
			config_reg <= `BMRP_RST_PACK_CONFIG | `BMRP_CFG_FIXED_ONES;
		end else if (cfg_wr) begin
			config_reg <= (i_wdata & `BMRP_CFG_WR_MASK) | `BMRP_CFG_FIXED_ONES;
		end
	end

	always @(posedge i_core_clk) begin
		if (pg2_wr) begin
			case (i_offset)
				`BMRP_OFS_NET_CHARGE: begin
					net_charge_reg <= i_wdata;
				end
				`BMRP_OFS_CHARGE_IN_LO: begin
					charge_in_reg[7:0] <= i_wdata;
				end
				`BMRP_OFS_CHARGE_IN_HI: begin
					charge_in_reg[15:8] <= i_wdata;
				end
				`BMRP_OFS_CHARGE_OUT_LO: begin
					charge_out_reg[7:0] <= i_wdata;
				end
				`BMRP_OFS_CHARGE_OUT_HI: begin
					charge_out_reg[15:8] <= i_wdata;
				end
				default: begin
					net_charge_reg <= net_charge_reg;
				end
			endcase
		end
	end

	// Pin state is sampled only when page 1 is touched
	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			pio_seen_reg <= 1'b0;
		end else if (pg1_access) begin
			pio_seen_reg <= i_pio_pin;
		end
	end

	bmrp_path_ctrl u_path (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_allow({charge_allow_reg, discharge_allow_reg}),
		.i_block({i_charge_block, i_discharge_block}),
		.o_drive_b(drive_b)
	);

	bmrp_user_mem u_mem (
		.i_core_clk(i_core_clk),
		.i_wr_en(user_wr),
		.i_addr(i_offset),
		.i_wdata(i_wdata),
		.o_rdata(user_rdata)
	);

	assign control_rd = {
		low_power_reg,
		refresh_reg,
		2'b00,
		drive_b[1],
		drive_b[0],
		charge_allow_reg,
		discharge_allow_reg
	};
	// Flags are live levels; only the pin is captured on access
	assign status_rd = {
		1'b0,
		pio_seen_reg,
		write_guard_reg,
		i_over_temp,
		i_over_volt,
		i_under_volt,
		i_over_current,
		i_low_cap_warn
	};

	// no supply gating on any access
	always @* begin
		rdata_next = `BMRP_RD_RESERVED;
		case (i_page)
			`BMRP_PAGE_CFG: begin
				case (i_offset)
					`BMRP_OFS_PACK_CONTROL: rdata_next = control_rd;
					`BMRP_OFS_DELAY_SELECT: rdata_next = delay_select_reg;
					`BMRP_OFS_LOW_CAP_THRESH: rdata_next = low_cap_thresh_reg;
					`BMRP_OFS_MAKER_ID_LO: rdata_next = MAKER_ID[7:0];
					`BMRP_OFS_MAKER_ID_HI: rdata_next = MAKER_ID[15:8];
					default: rdata_next = `BMRP_RD_RESERVED;
				endcase
			end
			`BMRP_PAGE_STAT: begin
				case (i_offset)
					`BMRP_OFS_PACK_STATUS: rdata_next = status_rd;
					`BMRP_OFS_TEMPERATURE: rdata_next = i_temperature;
					`BMRP_OFS_UNUSED_A: rdata_next = `BMRP_RD_UNUSED;
					`BMRP_OFS_UNUSED_B: rdata_next = `BMRP_RD_UNUSED;
					`BMRP_OFS_VOLTAGE_LO: rdata_next = i_voltage[7:0];
					`BMRP_OFS_VOLTAGE_HI: rdata_next = {6'h00, i_voltage[9:8]};
					default: rdata_next = `BMRP_RD_RESERVED;
				endcase
			end
			`BMRP_PAGE_MEAS: begin
				case (i_offset)
					`BMRP_OFS_NET_CHARGE: rdata_next = net_charge_reg;
					`BMRP_OFS_PACK_CONFIG: rdata_next = config_reg;
					`BMRP_OFS_CHARGE_IN_LO: rdata_next = charge_in_reg[7:0];
					`BMRP_OFS_CHARGE_IN_HI: rdata_next = charge_in_reg[15:8];
					`BMRP_OFS_CHARGE_OUT_LO: rdata_next = charge_out_reg[7:0];
					`BMRP_OFS_CHARGE_OUT_HI: rdata_next = charge_out_reg[15:8];
					`BMRP_OFS_CURRENT_LO: rdata_next = i_current[7:0];
					`BMRP_OFS_CURRENT_HI: rdata_next = i_current[15:8];
					default: rdata_next = `BMRP_RD_RESERVED;
				endcase
			end
			default: begin
				rdata_next = user_rdata;
			end
		endcase
	end

	// Read data held until the next read so a slow host can sample it
	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd;
			if (i_rd) begin
				o_rdata <= rdata_next;
			end
		end
	end

	assign o_charge_pin_b = drive_b[1];
	assign o_discharge_pin_b = drive_b[0];
	assign o_low_power_request = low_power_reg;
	assign o_refresh_mode_request = refresh_reg;
	assign o_overcurrent_release_time = delay_select_reg[`BMRP_DLY_RELEASE_HI:`BMRP_DLY_RELEASE_LO];
	assign o_overvoltage_delay = delay_select_reg[`BMRP_DLY_OVERVOLT_HI:`BMRP_DLY_OVERVOLT_LO];
	assign o_undervoltage_delay = delay_select_reg[`BMRP_DLY_UNDERVOLT_HI:`BMRP_DLY_UNDERVOLT_LO];
	assign o_overcurrent_delay = delay_select_reg[`BMRP_DLY_OVERCUR_HI:`BMRP_DLY_OVERCUR_LO];
	assign o_low_capacity_threshold = low_cap_thresh_reg;
	assign o_pack_configuration = config_reg;
	assign o_net_charge_accumulator = net_charge_reg;
	assign o_charge_in_accumulator = charge_in_reg;
	assign o_charge_out_accumulator = charge_out_reg;
endmodule // bmrp_regs

// >>> bmrp_regs_properties.sv
`timescale 1ns/1ps
module bmrp_regs_props (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire [1:0] i_page,
	input wire [4:0] i_offset,
	input wire i_rd,
	input wire i_dq,
	input wire i_charge_block,
	input wire i_discharge_block,
	input wire [7:0] o_rdata,
	input wire o_rd_valid,
	input wire o_charge_pin_b,
	input wire o_discharge_pin_b,
	input wire o_refresh_mode_request,
	input wire [1:0] o_overvoltage_delay,
	input wire [7:0] o_low_capacity_threshold
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (!i_rst_b);
a_read_answer_due: assert property (i_rd |=> o_rd_valid)
	else $error("read not answered");
a_no_stray_valid: assert property (!i_rd |=> !o_rd_valid)
	else $error("valid without read");
a_ctl_gap_zero: assert property (i_rd && i_page == 2'h0 && i_offset == 5'h00 |=> o_rdata[5:4] == 2'h0)
	else $error("control gap bits set");
a_reserved_all_ones: assert property (i_rd && i_page != 2'h3 && i_offset > 5'h07 |=> o_rdata == 8'hFF)
	else $error("reserved byte not FF");
a_unused_reads_zero: assert property (i_rd && i_page == 2'h1 && i_offset[4:1] == 4'h1 |=> o_rdata == 8'h00)
	else $error("unused byte not 00");
a_charge_block_off: assert property (i_charge_block |=> o_charge_pin_b)
	else $error("charge pin on while blocked");
a_dischg_block_off: assert property (i_discharge_block |=> o_discharge_pin_b)
	else $error("discharge pin on while blocked");
a_dq_fall_clears: assert property ($fell(i_dq) |=> !o_refresh_mode_request)
	else $error("refresh kept after data fall");
a_reset_loads_zero: assert property (disable iff (1'b0) !i_rst_b |=> o_overvoltage_delay == 2'h0 && o_low_capacity_threshold == 8'h00)
	else $error("reset defaults wrong");
endmodule // bmrp_regs_props
bind bmrp_regs bmrp_regs_props bmrp_regs_props_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
	.i_page(i_page), .i_offset(i_offset), .i_rd(i_rd), .i_dq(i_dq),
	.i_charge_block(i_charge_block), .i_discharge_block(i_discharge_block),
	.o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_charge_pin_b(o_charge_pin_b),
	.o_discharge_pin_b(o_discharge_pin_b), .o_refresh_mode_request(o_refresh_mode_request),
	.o_overvoltage_delay(o_overvoltage_delay), .o_low_capacity_threshold(o_low_capacity_threshold));

// >>> bmrp_host_model.sv
`timescale 1ns/1ps
module bmrp_host_model (
	input wire i_core_clk,
	input wire [7:0] i_rdata,
	input wire i_rd_valid,
	output logic [1:0] o_page = 2'h0,
	output logic [4:0] o_offset = 5'h00,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0,
	output logic [7:0] o_wdata = 8'h00,
	output logic o_lock = 1'b0,
	output logic o_unlock = 1'b0,
	output logic o_dq = 1'b1,
	output logic o_late = 1'b0
);
task wr(input [1:0] p, input [4:0] o, input [7:0] d);
	@(negedge i_core_clk);
	{o_page, o_offset, o_wdata, o_wr} = {p, o, d, 1'b1};
	@(negedge i_core_clk);
	o_wr = 1'b0;
	// Released data must not keep showing the last byte
	o_wdata = ~d;
endtask
task rd(input [1:0] p, input [4:0] o, output [7:0] d);
	int n;
	@(negedge i_core_clk);
	{o_page, o_offset, o_rd} = {p, o, 1'b1};
	@(negedge i_core_clk);
	o_rd = 1'b0;
	n = 0;
	while (i_rd_valid !== 1'b1 && n < 4) begin
		@(negedge i_core_clk);
		n++;
	end
	if (n == 4) o_late = 1'b1;
	d = i_rdata;
endtask
task cmd(input bit l);
	@(negedge i_core_clk);
	{o_lock, o_unlock} = {l, !l};
	@(negedge i_core_clk);
	{o_lock, o_unlock} = 2'h0;
endtask
// Bus has a pull-up, so the line idles high
task dq_fall;
	@(negedge i_core_clk);
	o_dq = 1'b0;
	repeat (2) @(negedge i_core_clk);
	o_dq = 1'b1;
endtask
endmodule // bmrp_host_model

// >>> test_battery_manager_register_pages.sv
`timescale 1ns/1ps
module test_battery_manager_register_pages;
// Arbitrary identifier value
localparam [15:0] ID = 16'hC3A5;
logic clk = 1'b0, rst_b = 1'b0, pio = 1'b0, ot = 1'b0, ov = 1'b0, uv = 1'b0, oc = 1'b0;
logic lcw = 1'b0, cb = 1'b0, db = 1'b0, guard_m = 1'b1;
logic [7:0] temp = 8'h00, ctl_m = 8'h03, dly_m = 8'h00, thr_m = 8'h00, cfg_m = 8'h83, net_m;
logic [7:0] usr_m [32];
logic [9:0] volt = 10'h000;
logic [15:0] cur = 16'h0000, cin_m, cout_m;
wire [1:0] pg, rls_sel, ov_sel, uv_sel, oc_sel, pb_m;
wire [4:0] of;
wire [7:0] wd, rdat, thr, cfg, net;
wire [15:0] cin, cout;
wire wr, rd, rv, lk, ul, dq, late, chb, dchb, lp, rf;
int miscompares = 0, samples_checked = 0;
assign pb_m = ~(ctl_m[1:0] & ~{cb, db});
bmrp_regs #(.MAKER_ID(ID)) bmrp_regs_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_page(pg),
	.i_offset(of), .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdat), .o_rd_valid(rv),
	.i_lock_cmd(lk), .i_unlock_cmd(ul), .i_dq(dq), .i_pio_pin(pio), .i_over_temp(ot),
	.i_over_volt(ov), .i_under_volt(uv), .i_over_current(oc), .i_low_cap_warn(lcw),
	.i_charge_block(cb), .i_discharge_block(db), .i_temperature(temp), .i_voltage(volt),
	.i_current(cur), .o_charge_pin_b(chb), .o_discharge_pin_b(dchb), .o_low_power_request(lp),
	.o_refresh_mode_request(rf), .o_overcurrent_release_time(rls_sel),
	.o_overvoltage_delay(ov_sel), .o_undervoltage_delay(uv_sel), .o_overcurrent_delay(oc_sel),
	.o_low_capacity_threshold(thr),
	.o_pack_configuration(cfg), .o_net_charge_accumulator(net),
	.o_charge_in_accumulator(cin), .o_charge_out_accumulator(cout));
bmrp_host_model bmrp_host_model_i (.i_core_clk(clk), .i_rdata(rdat), .i_rd_valid(rv),
	.o_page(pg), .o_offset(of), .o_wr(wr), .o_rd(rd), .o_wdata(wd), .o_lock(lk),
	.o_unlock(ul), .o_dq(dq), .o_late(late));
initial forever #2.5 clk = ~clk;
function automatic [7:0] ex(input [1:0] p, input [4:0] o);
	case (p)
		2'h0: ex = o == 0 ? {ctl_m[7:6], 2'h0, pb_m, ctl_m[1:0]} : o == 1 ? dly_m :
			o == 2 ? thr_m : o == 3 ? ID[7:0] : o == 4 ? ID[15:8] : 8'hFF;
		2'h1: ex = o == 0 ? {1'b0, pio, guard_m, ot, ov, uv, oc, lcw} : o == 1 ? temp :
			o < 4 ? 8'h00 : o == 4 ? volt[7:0] : o == 5 ? {6'h00, volt[9:8]} : 8'hFF;
		2'h2: ex = o == 0 ? net_m : o == 1 ? cfg_m | 8'h0C : o == 2 ? cin_m[7:0] :
			o == 3 ? cin_m[15:8] : o == 4 ? cout_m[7:0] : o == 5 ? cout_m[15:8] :
			o == 6 ? cur[7:0] : o == 7 ? cur[15:8] : 8'hFF;
		default: ex = usr_m[o];
	endcase
endfunction
task cmp(input string n, input [15:0] e, input [15:0] g);
	samples_checked++;
	if (g !== e) begin
		miscompares++;
		$display("BAD %s exp %h got %h", n, e, g);
	end
endtask
task bwr(input [1:0] p, input [4:0] o, input [7:0] d);
	bmrp_host_model_i.wr(p, o, d);
	if (p == 2'h0 && !guard_m) begin
		if (o == 5'h00) ctl_m = d & 8'hC3;
		if (o == 5'h01) dly_m = d;
		if (o == 5'h02) thr_m = d;
	end
	if (p == 2'h2) case (o)
		5'h00: net_m = d;
		5'h01: cfg_m = d;
		5'h02: cin_m[7:0] = d;
		5'h03: cin_m[15:8] = d;
		5'h04: cout_m[7:0] = d;
		5'h05: cout_m[15:8] = d;
		default: ;
	endcase
	if (p == 2'h3) usr_m[o] = d;
endtask
task brd(input [1:0] p, input [4:0] o);
	logic [7:0] d;
	bmrp_host_model_i.rd(p, o, d);
	cmp("rdata", ex(p, o), d);
endtask
// Pins follow one edge behind the enables
task pins;
	repeat (2) @(negedge clk);
	cmp("pins", pb_m, {chb, dchb});
endtask
task wrap_up;
	if (late) miscompares++;
	if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
initial begin
	#100000;
	miscompares++;
	wrap_up;
end
initial begin
	void'($urandom(14));
	temp = 8'($urandom);
	volt = 10'($urandom);
	cur = 16'($urandom);
	{pio, ot, ov, uv, oc, lcw} = 6'($urandom);
	repeat (10) @(negedge clk);
	rst_b = 1'b1;
	pins();
	brd(0, 0);
	brd(0, 1);
	brd(2, 1);
	cmp("config", cfg_m | 8'h0C, cfg);
	bwr(1, 0, 8'hFF);
	brd(1, 0);
	bwr(0, 2, 8'h5A);
	brd(0, 2);
	bmrp_host_model_i.cmd(0);
	guard_m = 1'b0;
	for (int k = 0; k < 4; k++) begin
		bwr(0, 1, {4{k[1:0]}});
		cmp("fields", dly_m, {rls_sel, ov_sel, uv_sel, oc_sel});
	end
	bwr(0, 1, 8'($urandom));
	cmp("fields", dly_m, {rls_sel, ov_sel, uv_sel, oc_sel});
	bwr(0, 2, 8'($urandom));
	cmp("thresh", thr_m, thr);
	bwr(0, 3, 8'h00);
	bwr(0, 4, 8'h00);
	bwr(0, 9, 8'h00);
	bwr(0, 0, 8'hBC);
	pins();
	cmp("lowpow", 1, lp);
	brd(0, 0);
	bwr(0, 0, 8'h43);
	pins();
	cmp("refresh", 1, rf);
	cb = 1'b1;
	pins();
	brd(0, 0);
	{cb, db} = 2'h1;
	pins();
	db = 1'b0;
	bmrp_host_model_i.dq_fall();
	ctl_m[6] = 1'b0;
	cmp("refresh", 0, rf);
	bmrp_host_model_i.cmd(1);
	guard_m = 1'b1;
	bwr(0, 2, ~thr_m);
	brd(0, 2);
	// Accumulators come up undefined, so the host loads them first
	for (int o = 0; o < 8; o++) bwr(2, o, 8'($urandom));
	cmp("net", net_m, net);
	cmp("cin", cin_m, cin);
	cmp("cout", cout_m, cout);
	cmp("config", cfg_m | 8'h0C, cfg);
	for (int o = 0; o < 32; o++) bwr(3, o, 8'($urandom));
	for (int n = 0; n < 128; n++) brd(n[6:5], n[4:0]);
	wrap_up;
end
endmodule // test_battery_manager_register_pages
